// File: common/bfb_defs.svh
`ifndef BFB_DEFS_SVH
`define BFB_DEFS_SVH
// Overview of operation
// R01: Buffer holds 32,768 bytes, written at one port, read in order at other.
// R02: Direction select high makes port A write, port B read; low swaps.
// R03: Request low starts a port cycle; ignored while that port's ready is low.
// R04: Empty output low exactly at zero stored bytes, high otherwise.
// R05: Four fill-level outputs show stored amount in 2K steps up to 32K.
// R06: Read ready low below 64 bytes; forced read lets all data out.
// R07: Lead/reread input high on lead or single device; low pulse rereads.
// R08: Chain input wired to previous chain output; lone device loops its own.
// R09: Reset high clears counters; reset, requests, lead stay high min width.
// R10: After reset the write-port ready rises so writing may start.
// R11: Writes fill two 64-byte registers in turn, full one moved to storage.
// R12: Write data captured on request rising edge; writer holds data around it.
// R13: Write ready high except full, forced read or reread; no write when low.
// R14: Reads come from two 64-byte registers in turn, emptied one refilled.
// R15: Read data follows request fall; bus floats when request high or unready.
// R16: Read ready high unless under 64 bytes or reread; requests ignored when low.
// R17: Stored amount is write count minus read count since last reset.
// R18: Full low at 32,705 to 32,768 bytes; write ready drops, writes ignored.
// R19: After full, write ready returns at 32,704 bytes or fewer.
// R20: After low data, read ready returns at 64 bytes or more.
// R21: Keep over 2K stored; drain remainder below 2K by forced read.
// R22: Forced read moves partial write register out; writes blocked until empty.
// R23: Low pulse on lead/reread resets read address counter to zero.
// R24: Fill-level outputs are binary count of 2048-byte blocks, first bit lowest.
// R25: Clocked side syncs strobes so reads and writes run independently; the host runs one port cycle at a time, alternating reads and writes when both wait.

`define BFB_DATA_W      8
`define BFB_FLAG_W      4
`define BFB_CNT_W       16
`define BFB_DEPTH       32768
`define BFB_CLK_NS      8
`define BFB_CYCLE_NS    100
`define BFB_ACCESS_NS   50
`define BFB_RST_MIN_NS  200
`define BFB_REREAD_NS   100
`define BFB_DIR_RST     1'b1
`define BFB_ACC_CYC     ((`BFB_ACCESS_NS + `BFB_CLK_NS - 1) / `BFB_CLK_NS)
`define BFB_CYC_CYC     ((`BFB_CYCLE_NS + `BFB_CLK_NS - 1) / `BFB_CLK_NS)
`define BFB_RECOV_CYC   (`BFB_CYC_CYC - `BFB_ACC_CYC)
`endif

// File: common/bfb_pkg.sv
`include "bfb_defs.svh"
package bfb_pkg;
	typedef enum logic [3:0] {
		bfb_st_rst,
		bfb_st_rst_recov,
		bfb_st_idle,
		bfb_st_wr_low,
		bfb_st_wr_high,
		bfb_st_rd_low,
		bfb_st_rd_high,
		bfb_st_rr_low,
		bfb_st_rr_recov
	} bfb_state_e;

	typedef struct packed {
		bfb_state_e                 state;
		logic                       dir;
		logic                       force_rd;
		logic                       lead;
		logic                       dev_rst;
		logic                       req_a_n;
		logic                       req_b_n;
		logic                       drive;
		logic [`BFB_DATA_W-1:0]     dout;
		logic [`BFB_DATA_W-1:0]     rd_data;
		logic                       rd_valid;
		logic [`BFB_CNT_W-1:0]      wr_cnt;
		logic [`BFB_CNT_W-1:0]      rd_cnt;
		logic [`BFB_FLAG_W-1:0]     fill;
		logic                       empty;
		logic                       full;
		logic                       need_force;
		logic                       last_wr;
	} bfb_ctl_s;

	typedef struct packed {
		logic [`BFB_CNT_W-1:0]      cnt;
	} bfb_tmr_s;
endpackage

// File: core/bfb_cycle_timer.sv
`timescale 1ns/100ps
`include "bfb_defs.svh"
module bfb_cycle_timer #(
	parameter logic [`BFB_CNT_W-1:0] INIT = '0
) (
	// Clock and control
	input  wire logic                  i_sys_clk,
	input  wire logic                  i_rst,
	input  wire logic                  i_ce,
	// Load and status
	input  wire logic                  i_load,
	input  wire logic [`BFB_CNT_W-1:0] i_load_value,
	output logic                       o_done
);
	bfb_pkg::bfb_tmr_s tmr_reg;
	bfb_pkg::bfb_tmr_s tmr_next;

	always_comb begin
		tmr_next = tmr_reg;
		if (i_load) begin
			tmr_next.cnt = i_load_value;
		end else if (tmr_reg.cnt != '0) begin
			tmr_next.cnt = tmr_reg.cnt - `BFB_CNT_W'(1);
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			tmr_reg.cnt <= INIT;
		end else if (i_ce) begin
			tmr_reg <= tmr_next;
		end
	end

	assign o_done = (tmr_reg.cnt == '0);
endmodule

// File: core/bfb_host_ctrl.sv
`timescale 1ns/100ps
`include "bfb_defs.svh"
module bfb_host_ctrl #(
	parameter int RESET_MIN_NS  = `BFB_RST_MIN_NS,
	parameter int REREAD_NS     = `BFB_REREAD_NS,
	parameter bit SINGLE_DEVICE = 1'b1 // [R07] [R08]
) (
	// Clock and control
	input  wire logic                    i_sys_clk,
	input  wire logic                    i_rst,
	input  wire logic                    i_ce,
	// User write side
	input  wire logic                    i_wr_valid,
	input  wire logic [`BFB_DATA_W-1:0]  i_wr_data,
	output logic                         o_wr_ready,
	// User read side
	input  wire logic                    i_rd_req,
	output logic                         o_rd_ack,
	output logic [`BFB_DATA_W-1:0]       o_rd_data,
	output logic                         o_rd_valid,
	// User commands
	input  wire logic                    i_dir_sel,
	input  wire logic                    i_force_read,
	input  wire logic                    i_reread,
	input  wire logic                    i_dev_reset,
	output logic                         o_busy,
	// User status
	output logic                         o_dev_empty,
	output logic                         o_dev_full,
	output logic [`BFB_FLAG_W-1:0]       o_fill_blocks,
	output logic [`BFB_CNT_W-1:0]        o_host_count,
	output logic                         o_needs_forced_read,
	// Device control pins
	output logic                         o_dev_reset,
	output logic                         o_port_direction_select,
	output logic                         o_forced_read_request,
	output logic                         o_lead_or_reread,
	output logic                         o_port_a_req_n,
	output logic                         o_port_b_req_n,
	input  wire logic                    i_port_a_ready,
	input  wire logic                    i_port_b_ready,
	// Device status pins
	input  wire logic                    i_empty_n,
	input  wire logic                    i_full_n,
	input  wire logic [`BFB_FLAG_W-1:0]  i_fill_level_outputs,
	// Device data buses
	input  wire logic [`BFB_DATA_W-1:0]  i_port_a_data_bus,
	output logic [`BFB_DATA_W-1:0]       o_port_a_data_bus,
	output logic                         o_port_a_data_bus_oe,
	input  wire logic [`BFB_DATA_W-1:0]  i_port_b_data_bus,
	output logic [`BFB_DATA_W-1:0]       o_port_b_data_bus,
	output logic                         o_port_b_data_bus_oe
);
	localparam logic [`BFB_CNT_W-1:0] ACC_CYC = `BFB_CNT_W'(`BFB_ACC_CYC);
	localparam logic [`BFB_CNT_W-1:0] RECOV_CYC = `BFB_CNT_W'(`BFB_RECOV_CYC);
	localparam logic [`BFB_CNT_W-1:0] RST_CYC = `BFB_CNT_W'((RESET_MIN_NS + `BFB_CLK_NS - 1) / `BFB_CLK_NS);
	localparam logic [`BFB_CNT_W-1:0] RR_CYC = `BFB_CNT_W'((REREAD_NS + `BFB_CLK_NS - 1) / `BFB_CLK_NS);
	localparam bfb_pkg::bfb_ctl_s CTL_RST = '{
		state: bfb_pkg::bfb_st_rst, dir: `BFB_DIR_RST, lead: 1'b1, dev_rst: 1'b1,
		req_a_n: 1'b1, req_b_n: 1'b1, default: '0};

	bfb_pkg::bfb_ctl_s ctl_reg;
	bfb_pkg::bfb_ctl_s ctl_next;
	logic                  tmr_load;
	logic [`BFB_CNT_W-1:0] tmr_value;
	logic                  tmr_done;
	logic                  wr_port_rdy;
	logic                  rd_port_rdy;
	logic                  cmd_base;
	logic                  reread_go;
	logic                  want_rd;
	logic                  wr_ok;
	logic                  rd_ok;

	bfb_cycle_timer #(
		.INIT         (RST_CYC)
	) u_timer (
		.i_sys_clk    (i_sys_clk),
		.i_rst        (i_rst),
		.i_ce         (i_ce),
		.i_load       (tmr_load),
		.i_load_value (tmr_value),
		.o_done       (tmr_done)
	);

	// Port roles follow the direction select
	assign wr_port_rdy = ctl_reg.dir ? i_port_a_ready : i_port_b_ready; // [R02]
	assign rd_port_rdy = ctl_reg.dir ? i_port_b_ready : i_port_a_ready; // [R02]
	assign reread_go   = i_reread & SINGLE_DEVICE; // [R07]
	// Mode pins change only while both requests are high
	assign cmd_base = (ctl_reg.state == bfb_pkg::bfb_st_idle) & ~i_dev_reset & ~reread_go
		& (i_dir_sel == ctl_reg.dir) & (i_force_read == ctl_reg.force_rd);
	// Alternate when both sides are waiting
	assign want_rd    = i_rd_req & rd_port_rdy;
	assign wr_ok      = cmd_base & wr_port_rdy & ~(want_rd & ctl_reg.last_wr); // [R03] [R10] [R13] [R18] [R19]
	assign rd_ok      = cmd_base & rd_port_rdy & ~(i_wr_valid & wr_ok); // [R03] [R06] [R16] [R20]
	assign o_wr_ready = wr_ok;
	assign o_rd_ack   = rd_ok & i_rd_req;

	always_comb begin
		ctl_next          = ctl_reg;
		tmr_load          = 1'b0;
		tmr_value         = RECOV_CYC;
		ctl_next.rd_valid = 1'b0;
		// Status pins relayed one cycle late
		ctl_next.empty      = ~i_empty_n; // [R04]
		ctl_next.full       = ~i_full_n; // [R18]
		ctl_next.fill       = i_fill_level_outputs; // [R05] [R24]
		ctl_next.need_force = (i_fill_level_outputs == '0) & i_empty_n & ~rd_port_rdy; // [R21]
		unique case (ctl_reg.state)
			bfb_pkg::bfb_st_rst: begin
				// Reset, both requests and lead held high together
				ctl_next.dev_rst = 1'b1; // [R09]
				ctl_next.req_a_n = 1'b1;
				ctl_next.req_b_n = 1'b1;
				ctl_next.lead    = 1'b1;
				ctl_next.drive   = 1'b0;
				ctl_next.wr_cnt  = '0; // [R17]
				ctl_next.rd_cnt  = '0;
				if (tmr_done) begin
					ctl_next.dev_rst = 1'b0;
					ctl_next.state   = bfb_pkg::bfb_st_rst_recov;
					tmr_load         = 1'b1;
				end
			end
			bfb_pkg::bfb_st_rst_recov, bfb_pkg::bfb_st_rr_recov, bfb_pkg::bfb_st_rd_high: begin
				if (tmr_done) begin
					ctl_next.state = bfb_pkg::bfb_st_idle;
				end
			end
			bfb_pkg::bfb_st_idle: begin
				if (i_dev_reset) begin
					ctl_next.state   = bfb_pkg::bfb_st_rst;
					ctl_next.dev_rst = 1'b1;
					tmr_load         = 1'b1;
					tmr_value        = RST_CYC;
				end else if (reread_go) begin
					ctl_next.state  = bfb_pkg::bfb_st_rr_low;
					ctl_next.lead   = 1'b0; // [R23]
					ctl_next.rd_cnt = '0; // [R23]
					tmr_load        = 1'b1;
					tmr_value       = RR_CYC;
				end else if (i_dir_sel != ctl_reg.dir || i_force_read != ctl_reg.force_rd) begin
					ctl_next.dir      = i_dir_sel; // [R02]
					ctl_next.force_rd = i_force_read; // [R06] [R22]
				end else if (wr_ok && i_wr_valid) begin
					ctl_next.state   = bfb_pkg::bfb_st_wr_low;
					ctl_next.dout    = i_wr_data;
					ctl_next.drive   = 1'b1;
					ctl_next.req_a_n = ~ctl_reg.dir; // [R03]
					ctl_next.req_b_n = ctl_reg.dir; // [R03]
					ctl_next.last_wr = 1'b1;
					tmr_load         = 1'b1;
					tmr_value        = ACC_CYC;
				end else if (rd_ok && i_rd_req) begin
					ctl_next.state   = bfb_pkg::bfb_st_rd_low;
					ctl_next.req_a_n = ctl_reg.dir; // [R03]
					ctl_next.req_b_n = ~ctl_reg.dir; // [R03]
					ctl_next.last_wr = 1'b0;
					tmr_load         = 1'b1;
					tmr_value        = ACC_CYC;
				end
			end
			bfb_pkg::bfb_st_wr_low: begin
				if (tmr_done) begin
					// Rising request edge latches the byte in the device
					ctl_next.req_a_n = 1'b1; // [R12]
					ctl_next.req_b_n = 1'b1;
					ctl_next.wr_cnt  = ctl_reg.wr_cnt + `BFB_CNT_W'(1); // [R17]
					ctl_next.state   = bfb_pkg::bfb_st_wr_high;
					tmr_load         = 1'b1;
				end
			end
			bfb_pkg::bfb_st_wr_high: begin
				// Data kept on the bus through recovery for hold time
				if (tmr_done) begin
					ctl_next.drive = 1'b0; // [R12]
					ctl_next.state = bfb_pkg::bfb_st_idle;
				end
			end
			bfb_pkg::bfb_st_rd_low: begin
				if (tmr_done) begin
					// Sampled after the access time has elapsed
					ctl_next.rd_data  = ctl_reg.dir ? i_port_b_data_bus : i_port_a_data_bus; // [R15]
					ctl_next.rd_valid = 1'b1;
					ctl_next.rd_cnt   = ctl_reg.rd_cnt + `BFB_CNT_W'(1); // [R17]
					ctl_next.req_a_n  = 1'b1;
					ctl_next.req_b_n  = 1'b1;
					ctl_next.state    = bfb_pkg::bfb_st_rd_high;
					tmr_load          = 1'b1;
				end
			end
			bfb_pkg::bfb_st_rr_low: begin
				if (tmr_done) begin
					ctl_next.lead  = 1'b1; // [R07]
					ctl_next.state = bfb_pkg::bfb_st_rr_recov;
					tmr_load       = 1'b1;
				end
			end
		endcase
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			ctl_reg <= CTL_RST;
		end else if (i_ce) begin
			ctl_reg <= ctl_next;
		end
	end

	assign o_rd_data               = ctl_reg.rd_data;
	assign o_rd_valid              = ctl_reg.rd_valid;
	assign o_busy                  = (ctl_reg.state != bfb_pkg::bfb_st_idle);
	assign o_dev_empty             = ctl_reg.empty;
	assign o_dev_full              = ctl_reg.full;
	assign o_fill_blocks           = ctl_reg.fill;
	assign o_host_count            = ctl_reg.wr_cnt - ctl_reg.rd_cnt; // [R17]
	assign o_needs_forced_read     = ctl_reg.need_force;
	assign o_dev_reset             = ctl_reg.dev_rst;
	assign o_port_direction_select = ctl_reg.dir;
	assign o_forced_read_request   = ctl_reg.force_rd;
	assign o_lead_or_reread        = ctl_reg.lead;
	assign o_port_a_req_n          = ctl_reg.req_a_n;
	assign o_port_b_req_n          = ctl_reg.req_b_n;
	assign o_port_a_data_bus       = ctl_reg.dout;
	assign o_port_b_data_bus       = ctl_reg.dout;
	assign o_port_a_data_bus_oe    = ctl_reg.drive & ctl_reg.dir; // [R02]
	assign o_port_b_data_bus_oe    = ctl_reg.drive & ~ctl_reg.dir; // [R02]

	// Assertion helpers
	localparam int LOW_HOLD = `BFB_ACC_CYC;
	logic [`BFB_CNT_W-1:0] rst_len;
	logic                  wr_req_n;
	always_ff @(posedge i_sys_clk) begin
		if (i_rst || !ctl_reg.dev_rst) begin
			rst_len <= '0;
		end else if (i_ce) begin
			rst_len <= rst_len + `BFB_CNT_W'(1);
		end
	end
	assign wr_req_n = ctl_reg.dir ? ctl_reg.req_a_n : ctl_reg.req_b_n;

	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (i_rst);

	property p_wr_needs_ready; // [R03]
		$fell(wr_req_n) |-> $past(wr_port_rdy);
	endproperty
	a_wr_needs_ready: assert property (p_wr_needs_ready) else $error("write strobe without ready");

	property p_rd_needs_ready; // [R03]
		($fell(o_port_a_req_n) && !o_port_direction_select) || ($fell(o_port_b_req_n) && o_port_direction_select)
			|-> $past(rd_port_rdy);
	endproperty
	a_rd_needs_ready: assert property (p_rd_needs_ready) else $error("read strobe without ready");

	property p_reset_quiet; // [R09]
		o_dev_reset |-> o_port_a_req_n && o_port_b_req_n && o_lead_or_reread;
	endproperty
	a_reset_quiet: assert property (p_reset_quiet) else $error("request or lead low during reset");

	property p_reset_width; // [R09]
		$fell(o_dev_reset) |-> $past(rst_len) >= RST_CYC;
	endproperty
	a_reset_width: assert property (p_reset_width) else $error("device reset too short");

	property p_wr_data_held; // [R12]
		$rose(wr_req_n) |-> (o_port_a_data_bus_oe || o_port_b_data_bus_oe) && $stable(o_port_a_data_bus);
	endproperty
	a_wr_data_held: assert property (p_wr_data_held) else $error("write data dropped at strobe edge");

	property p_strobe_len; // [R12]
		($fell(o_port_a_req_n) && i_ce) |-> ##[LOW_HOLD:LOW_HOLD] !o_port_a_req_n;
	endproperty
	a_strobe_len: assert property (p_strobe_len) else $error("request low phase too short");

	property p_dir_stable; // [R02]
		!(o_port_a_req_n && o_port_b_req_n) |-> $stable(o_port_direction_select) && $stable(o_forced_read_request);
	endproperty
	a_dir_stable: assert property (p_dir_stable) else $error("mode pin moved during a request");

	property p_reread_quiet; // [R07]
		!o_lead_or_reread |-> o_port_a_req_n && o_port_b_req_n && SINGLE_DEVICE;
	endproperty
	a_reread_quiet: assert property (p_reread_quiet) else $error("reread pulse with request low");

	property p_wr_counted; // [R17]
		$rose(wr_req_n) |-> o_host_count == $past(o_host_count) + `BFB_CNT_W'(1);
	endproperty
	a_wr_counted: assert property (p_wr_counted) else $error("stored count not advanced on write");

	property p_need_force; // [R21]
		o_needs_forced_read |-> $past(i_fill_level_outputs == '0 && i_empty_n);
	endproperty
	a_need_force: assert property (p_need_force) else $error("forced read hint without low data");
endmodule

// File: tb/bfb_dev_model.sv
`timescale 1ns/100ps
`include "bfb_defs.svh"
module bfb_dev_model (
	// Control pins
	input  wire logic                   i_rst,
	input  wire logic                   i_dir,
	input  wire logic                   i_force,
	input  wire logic                   i_lead_n,
	input  wire logic                   i_req_a_n,
	input  wire logic                   i_req_b_n,
	// Data buses
	input  wire logic [`BFB_DATA_W-1:0] i_bus_a,
	input  wire logic [`BFB_DATA_W-1:0] i_bus_b,
	output logic [`BFB_DATA_W-1:0]      o_bus_a,
	output logic [`BFB_DATA_W-1:0]      o_bus_b,
	// Status pins
	output logic                        o_ready_a,
	output logic                        o_ready_b,
	output logic                        o_empty_n,
	output logic                        o_full_n,
	output logic [`BFB_FLAG_W-1:0]      o_flags
);
	logic [`BFB_DATA_W-1:0] mem [0:`BFB_DEPTH-1];
	logic [`BFB_DATA_W-1:0] rval = 8'h00;
	logic                   w_ok = 1'b0;
	logic                   r_ok = 1'b0;
	logic                   rdrv = 1'b0;
	logic                   wr_rdy;
	logic                   rd_rdy;
	logic                   wreq_n;
	logic                   rreq_n;
	int                     wcnt = 0;
	int                     rcnt = 0;
	int                     stored;

	assign stored = wcnt - rcnt;
	assign wreq_n = i_dir ? i_req_a_n : i_req_b_n;
	assign rreq_n = i_dir ? i_req_b_n : i_req_a_n;
	assign wr_rdy = !i_rst && i_lead_n && !(i_force && stored > 0) && stored < 32705;
	// A read register already filled keeps serving until its 64 bytes are out
	assign rd_rdy = !i_rst && i_lead_n && (stored >= 64 || (stored > 0 && (i_force || rcnt % 64 != 0)));
	assign o_ready_a = i_dir ? wr_rdy : rd_rdy;
	assign o_ready_b = i_dir ? rd_rdy : wr_rdy;
	assign o_empty_n = stored != 0;
	assign o_full_n = stored < 32705;
	assign o_flags = (stored == 0) ? 4'h0 : 4'((stored - 1) / 2048);
	// Released bus shows the inverse of the last byte
	assign o_bus_a = (rdrv && !i_dir) ? rval : ~rval;
	assign o_bus_b = (rdrv && i_dir) ? rval : ~rval;

	always @(posedge i_rst) begin
		wcnt = 0;
		rcnt = 0;
	end
	always @(negedge i_lead_n) rcnt = 0;
	always @(negedge wreq_n) w_ok = wr_rdy;
	always @(posedge wreq_n) begin
		if (w_ok && !i_rst) begin
			mem[wcnt % `BFB_DEPTH] = i_dir ? i_bus_a : i_bus_b;
			wcnt++;
		end
	end
	always @(negedge rreq_n) begin
		r_ok = rd_rdy;
		if (r_ok) begin
			#(`BFB_ACCESS_NS);
			rval = mem[rcnt % `BFB_DEPTH];
			rdrv = 1'b1;
		end
	end
	always @(posedge rreq_n) begin
		if (r_ok && !i_rst) rcnt++;
		rdrv = 1'b0;
	end
endmodule

// File: tb/testbench.sv
`timescale 1ns/100ps
`include "bfb_defs.svh"
module testbench;
	logic                   i_sys_clk = 1'b0;
	logic                   i_rst = 1'b1;
	logic                   i_wr_valid = 1'b0;
	logic [7:0]             i_wr_data = 8'h00;
	logic                   i_rd_req = 1'b0;
	logic                   i_dir_sel = 1'b1;
	logic                   i_force_read = 1'b0;
	logic                   i_reread = 1'b0;
	logic                   i_dev_reset = 1'b0;
	logic                   i_ce = 1'b1;
	logic                   o_wr_ready, o_rd_ack, o_rd_valid, o_busy, o_dev_empty, o_dev_full, o_needs_forced_read;
	logic [7:0]             o_rd_data;
	logic [3:0]             o_fill_blocks, flags;
	logic [15:0]            o_host_count;
	logic                   dev_rst, dir, frc, lead, req_a_n, req_b_n, rdy_a, rdy_b, empty_n, full_n;
	logic [7:0]             h_a, h_b, d_a, d_b, bus_a, bus_b;
	logic                   oe_a, oe_b;
	int                     fails = 0;
	int                     check_count = 0;
	int                     i;

	always #(`BFB_CLK_NS / 2.0) i_sys_clk = ~i_sys_clk;
	assign bus_a = oe_a ? h_a : d_a;
	assign bus_b = oe_b ? h_b : d_b;

	bfb_host_ctrl DUT (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_ce(i_ce), .i_wr_valid(i_wr_valid),
		.i_wr_data(i_wr_data), .o_wr_ready(o_wr_ready), .i_rd_req(i_rd_req), .o_rd_ack(o_rd_ack),
		.o_rd_data(o_rd_data), .o_rd_valid(o_rd_valid), .i_dir_sel(i_dir_sel), .i_force_read(i_force_read),
		.i_reread(i_reread), .i_dev_reset(i_dev_reset), .o_busy(o_busy), .o_dev_empty(o_dev_empty),
		.o_dev_full(o_dev_full), .o_fill_blocks(o_fill_blocks), .o_host_count(o_host_count),
		.o_needs_forced_read(o_needs_forced_read), .o_dev_reset(dev_rst), .o_port_direction_select(dir),
		.o_forced_read_request(frc), .o_lead_or_reread(lead), .o_port_a_req_n(req_a_n),
		.o_port_b_req_n(req_b_n), .i_port_a_ready(rdy_a), .i_port_b_ready(rdy_b), .i_empty_n(empty_n),
		.i_full_n(full_n), .i_fill_level_outputs(flags), .i_port_a_data_bus(bus_a), .o_port_a_data_bus(h_a),
		.o_port_a_data_bus_oe(oe_a), .i_port_b_data_bus(bus_b), .o_port_b_data_bus(h_b),
		.o_port_b_data_bus_oe(oe_b));

	bfb_dev_model MODEL (.i_rst(dev_rst), .i_dir(dir), .i_force(frc), .i_lead_n(lead), .i_req_a_n(req_a_n),
		.i_req_b_n(req_b_n), .i_bus_a(bus_a), .i_bus_b(bus_b), .o_bus_a(d_a), .o_bus_b(d_b),
		.o_ready_a(rdy_a), .o_ready_b(rdy_b), .o_empty_n(empty_n), .o_full_n(full_n), .o_flags(flags));

	function automatic logic [7:0] pat(input int n);
		return 8'(n * 7 + 3);
	endfunction

	task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
		check_count++;
		if (got !== exp) begin
			fails++;
			$display("[FAIL] %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic wait_idle;
		int n;
		n = 0;
		repeat (3) @(negedge i_sys_clk);
		while (o_busy !== 1'b0 && n < 200) begin
			n++;
			@(negedge i_sys_clk);
		end
		chk("o_busy", 16'h0000, {15'h0000, o_busy});
	endtask

	task automatic wr(input logic [7:0] d);
		int n;
		n = 0;
		@(posedge i_sys_clk);
		i_wr_valid <= 1'b1;
		i_wr_data <= d;
		@(negedge i_sys_clk);
		while (o_wr_ready !== 1'b1 && n < 2000) begin
			n++;
			@(negedge i_sys_clk);
		end
		if (n >= 2000) chk("o_wr_ready", 16'h0001, {15'h0000, o_wr_ready});
		@(posedge i_sys_clk);
		i_wr_valid <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] e);
		int n;
		n = 0;
		@(posedge i_sys_clk);
		i_rd_req <= 1'b1;
		@(negedge i_sys_clk);
		while (o_rd_ack !== 1'b1 && n < 2000) begin
			n++;
			@(negedge i_sys_clk);
		end
		@(posedge i_sys_clk);
		i_rd_req <= 1'b0;
		n = 0;
		@(negedge i_sys_clk);
		while (o_rd_valid !== 1'b1 && n < 20) begin
			n++;
			@(negedge i_sys_clk);
		end
		chk("o_rd_data", {8'h00, e}, {8'h00, o_rd_data});
	endtask

	// One-cycle command strobe: 1 = device reset, 0 = reread
	task automatic pulse(input logic kind);
		wait_idle();
		@(posedge i_sys_clk);
		if (kind) i_dev_reset <= 1'b1;
		else i_reread <= 1'b1;
		@(posedge i_sys_clk);
		i_dev_reset <= 1'b0;
		i_reread <= 1'b0;
	endtask

	task automatic give_verdict;
		$display("checks %0d fails %0d", check_count, fails);
		if (fails == 0 && check_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	initial begin
		repeat (100000) @(posedge i_sys_clk);
		fails++;
		give_verdict();
	end

	initial begin
		repeat (12) @(posedge i_sys_clk);
		i_rst <= 1'b0;
		wait_idle();
		chk("o_dev_empty", 16'h0001, {15'h0000, o_dev_empty});
		chk("o_wr_ready", 16'h0001, {15'h0000, o_wr_ready});
		chk("dir", 16'h0001, {15'h0000, dir});
		for (i = 0; i < 63; i++) wr(pat(i));
		wait_idle();
		chk("o_needs_forced_read", 16'h0001, {15'h0000, o_needs_forced_read});
		chk("o_host_count", 16'h003f, o_host_count);
		chk("o_dev_empty", 16'h0000, {15'h0000, o_dev_empty});
		wr(pat(63));
		for (i = 0; i < 64; i++) rd(pat(i));
		wait_idle();
		chk("o_dev_empty", 16'h0001, {15'h0000, o_dev_empty});
		@(posedge i_sys_clk);
		i_dir_sel <= 1'b0;
		wait_idle();
		chk("dir", 16'h0000, {15'h0000, dir});
		for (i = 0; i < 70; i++) wr(pat(i + 100));
		for (i = 0; i < 64; i++) rd(pat(i + 100));
		wait_idle();
		@(posedge i_sys_clk);
		i_force_read <= 1'b1;
		wait_idle();
		chk("frc", 16'h0001, {15'h0000, frc});
		chk("o_wr_ready", 16'h0000, {15'h0000, o_wr_ready});
		for (i = 0; i < 6; i++) rd(pat(i + 164));
		wait_idle();
		chk("o_dev_empty", 16'h0001, {15'h0000, o_dev_empty});
		@(posedge i_sys_clk);
		i_force_read <= 1'b0;
		pulse(1'b1);
		// Frozen clock enable must hold the device reset past its normal length
		@(posedge i_sys_clk);
		i_ce <= 1'b0;
		repeat (40) @(negedge i_sys_clk);
		chk("dev_rst", 16'h0001, {15'h0000, dev_rst});
		@(posedge i_sys_clk);
		i_ce <= 1'b1;
		wait_idle();
		chk("o_host_count", 16'h0000, o_host_count);
		chk("o_dev_empty", 16'h0001, {15'h0000, o_dev_empty});
		for (i = 0; i < 64; i++) wr(pat(i + 50));
		for (i = 0; i < 64; i++) rd(pat(i + 50));
		pulse(1'b0);
		repeat (3) @(negedge i_sys_clk);
		chk("lead", 16'h0000, {15'h0000, lead});
		wait_idle();
		chk("o_host_count", 16'h0040, o_host_count);
		for (i = 0; i < 64; i++) rd(pat(i + 50));
		for (i = 0; i < 2112; i++) wr(pat(i));
		wait_idle();
		chk("o_fill_blocks", 16'(2112 / 2048), {12'h000, o_fill_blocks});
		chk("o_dev_full", 16'h0000, {15'h0000, o_dev_full});
		chk("o_host_count", 16'h0840, o_host_count);
		give_verdict();
	end
endmodule
